// ---- core/sapc_defs.svh ----
// Summary of operation
// - A software start is accepted only while the device runs in a Run mode; a trigger start needs no Run mode.
// - A running conversion continues and completes in the matching Idle mode.
// - Zero acquisition field delays conversion start one instruction cycle for Sleep entry.
// - Unimplemented control register bits read as zero.
// - Completion clears go/done, sets done flag and resumes sampling the channel.
// - Zero acquisition field means conversion starts after the one-instruction-cycle delay; software times acquisition.
// - Each 12-bit conversion takes eleven conversion clock periods.
// - After completion or abort, wait two conversion clock periods before sampling.
`ifndef SAPC_DEFS_SVH
`define SAPC_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SAPC_OFF_RES_HI   3'h0
`define SAPC_OFF_RES_LO   3'h1
`define SAPC_OFF_CTL_MAIN 3'h2
`define SAPC_OFF_CTL_REF  3'h3
`define SAPC_OFF_CTL_TIM  3'h4
`define SAPC_OFF_INT_STAT 3'h5
`define SAPC_OFF_INT_CTL  3'h6

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define SAPC_BIT_DONE_FLAG 0
`define SAPC_BIT_INT_EN    0
`define SAPC_BIT_INT_PRIO  1
`define SAPC_RST_BYTE      8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SAPC_MCLK_NS     40
`define SAPC_RC_TAD_NS   4000
`define SAPC_RC_TAD_CYC  ((`SAPC_RC_TAD_NS + `SAPC_MCLK_NS - 1) / `SAPC_MCLK_NS)
`define SAPC_INSTR_TOSC  4
`define SAPC_CONV_TADS   11
`define SAPC_WAIT_TADS   2

`endif

// ---- core/sapc_pkg.sv ----
package sapc_pkg;

  // ----------------------------------------------------------------------
  // Register layouts
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       cal_req;      // offset_calibrate_request
    logic       rsvd;
    logic [3:0] chan;         // input_channel_select
    logic       go;           // go/done
    logic       on;           // converter_power_on
  } sapc_ctl_main_t;

  typedef struct packed {
    logic       trig_sel;     // special_trigger_select
    logic       rsvd;
    logic [1:0] vref;         // reference_voltage_select
    logic [3:0] pins;         // analog_pin_config
  } sapc_ctl_ref_t;

  typedef struct packed {
    logic       right_just;   // result_justify_select
    logic       rsvd;
    logic [2:0] acq_sel;      // acquisition_time_select
    logic [2:0] clk_sel;      // conversion_clock_select
  } sapc_ctl_tim_t;

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SAMPLE = 3'b000,
    ST_DELAY  = 3'b001,
    ST_ACQ    = 3'b010,
    ST_CONV   = 3'b011,
    ST_WAIT   = 3'b100
  } sapc_state_t;

endpackage

// ---- core/sapc_tad_gen.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "sapc_defs.svh"

module sapc_tad_gen (
  input  wire logic       mclk_i,     // System clock
  input  wire logic       resetn_i,   // Async reset, active low
  input  wire logic       restart_i,  // Realign period to now
  input  wire logic       sleep_i,    // Device in Sleep
  input  wire logic [2:0] clk_sel_i,  // Conversion clock select
  output logic            tick_o      // One pulse per period
);

  logic [6:0] cnt_q;
  logic [6:0] limit;
  logic       rc_sel;

  // Cycles per conversion clock period
  function automatic logic [6:0] period_cyc(input logic [2:0] sel);
    unique case (sel)
      3'b000:  period_cyc = 7'h02;
      3'b100:  period_cyc = 7'h04;
      3'b001:  period_cyc = 7'h08;
      3'b101:  period_cyc = 7'h10;
      3'b010:  period_cyc = 7'h20;
      3'b110:  period_cyc = 7'h40;
      default: period_cyc = 7'(`SAPC_RC_TAD_CYC);
    endcase
  endfunction

  assign rc_sel = (clk_sel_i[1:0] == 2'b11);
  assign limit  = period_cyc(clk_sel_i);

  // Oscillator-derived periods stop in Sleep; only the RC source runs on
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q  <= 7'h00;
      tick_o <= 1'b0;
    end else if (restart_i) begin
      cnt_q  <= 7'h00;
      tick_o <= 1'b0;
    end else if (sleep_i && !rc_sel) begin
      tick_o <= 1'b0;
    end else if (cnt_q >= limit - 7'h01) begin
      cnt_q  <= 7'h00;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 7'h01;
      tick_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ---- core/sapc_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "sapc_defs.svh"

module sapc_top (
  input  wire logic        mclk_i,       // System clock, 25 MHz
  input  wire logic        resetn_i,     // Async reset, active low
  input  wire logic [2:0]  addr_i,       // Register address
  input  wire logic [7:0]  wdata_i,      // Write data
  input  wire logic        wr_i,         // Write strobe
  input  wire logic        rd_i,         // Read strobe
  output logic      [7:0]  rdata_o,      // Read data, cycle after rd_i
  input  wire logic        cpu_run_i,    // Device in a Run mode
  input  wire logic        sleep_i,      // Device in Sleep
  input  wire logic        trig_i,       // Special event trigger pulse
  input  wire logic [11:0] sample_code_i,// Raw converter code
  output logic      [3:0]  chan_sel_o,   // Selected input channel
  output logic      [1:0]  vref_sel_o,   // Reference selection
  output logic      [3:0]  pin_cfg_o,    // Analog pin configuration
  output logic             irq_o,        // Done interrupt, level
  output logic             irq_prio_o    // Done interrupt priority
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  sapc_pkg::sapc_ctl_main_t ctl_main_q;
  sapc_pkg::sapc_ctl_ref_t  ctl_ref_q;
  sapc_pkg::sapc_ctl_tim_t  ctl_tim_q;
  sapc_pkg::sapc_state_t    state_q;
  logic [7:0]  res_hi_q;
  logic [7:0]  res_lo_q;
  logic [11:0] offset_q;
  logic        dummy_q;
  logic        done_flag_q;
  logic        int_en_q;
  logic        int_prio_q;
  logic [4:0]  cnt_q;
  logic        done_q;

  logic        tad_tick;
  logic        tad_restart;
  logic        wr_main;
  logic        go_req;
  logic        abort;
  logic        start;
  logic        busy;
  logic [4:0]  acq_tads;
  logic [11:0] cal_code;

  // Acquisition length in conversion clock periods
  function automatic logic [4:0] acq_len(input logic [2:0] sel);
    unique case (sel)
      3'b000:  acq_len = 5'h00;
      3'b001:  acq_len = 5'h02;
      3'b010:  acq_len = 5'h04;
      3'b011:  acq_len = 5'h06;
      3'b100:  acq_len = 5'h08;
      3'b101:  acq_len = 5'h0C;
      3'b110:  acq_len = 5'h10;
      default: acq_len = 5'h14;
    endcase
  endfunction

  // Register address decode for the write paths; the read port decodes addr_i in its own case
  function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
    hit = (a == off);
  endfunction

  // ----------------------------------------------------------------------
  // Start, abort and phase decode
  // ----------------------------------------------------------------------
  assign wr_main  = wr_i && hit(addr_i, `SAPC_OFF_CTL_MAIN);
  assign acq_tads = acq_len(ctl_tim_q.acq_sel);
  assign busy     = (state_q == sapc_pkg::ST_DELAY) || (state_q == sapc_pkg::ST_ACQ) ||
                    (state_q == sapc_pkg::ST_CONV);

  // Software go needs the converter already on and the core running; a trigger needs only trig_sel set and the converter on
  assign go_req = (wr_main && wdata_i[1] && ctl_main_q.on && cpu_run_i) ||
                  (trig_i && ctl_ref_q.trig_sel && ctl_main_q.on);

  // Clearing go or power during a conversion throws the sample away
  assign abort = busy && ((wr_main && (!wdata_i[1] || !wdata_i[0])) || !ctl_main_q.on);

  assign start = ctl_main_q.go && !busy &&
                 ((state_q == sapc_pkg::ST_SAMPLE) ||
                  (state_q == sapc_pkg::ST_WAIT && tad_tick && cnt_q == 5'(`SAPC_WAIT_TADS - 1)));

  assign tad_restart = start || abort || (state_q == sapc_pkg::ST_DELAY) ||
                       (state_q == sapc_pkg::ST_CONV && tad_tick && cnt_q == 5'(`SAPC_CONV_TADS - 1));

  // Offset-compensated code, floored at zero
  assign cal_code = (sample_code_i > offset_q) ? (sample_code_i - offset_q) : 12'h000;

  // ----------------------------------------------------------------------
  // Conversion clock generator
  // ----------------------------------------------------------------------
  sapc_tad_gen u_tad (
    .mclk_i    (mclk_i),
    .resetn_i  (resetn_i),
    .restart_i (tad_restart),
    .sleep_i   (sleep_i),
    .clk_sel_i (ctl_tim_q.clk_sel),
    .tick_o    (tad_tick)
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Keeps ticking in Idle; only the core halts, not the conversion
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= sapc_pkg::ST_SAMPLE;
      cnt_q   <= 5'h00;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        sapc_pkg::ST_SAMPLE: begin
          cnt_q <= 5'h00;
          if (start) begin
            // Zero field: short start delay instead of acquisition
            state_q <= (acq_tads == 5'h00) ? sapc_pkg::ST_DELAY : sapc_pkg::ST_ACQ;
          end
        end
        sapc_pkg::ST_DELAY: begin
          // One instruction cycle lets the sleep instruction run first
          if (abort) begin
            state_q <= sapc_pkg::ST_WAIT;
            cnt_q   <= 5'h00;
          end else if (cnt_q == 5'(`SAPC_INSTR_TOSC - 1)) begin
            state_q <= sapc_pkg::ST_CONV;
            cnt_q   <= 5'h00;
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        sapc_pkg::ST_ACQ: begin
          if (abort) begin
            state_q <= sapc_pkg::ST_WAIT;
            cnt_q   <= 5'h00;
          end else if (tad_tick && cnt_q == acq_tads - 5'h01) begin
            state_q <= sapc_pkg::ST_CONV;
            cnt_q   <= 5'h00;
          end else if (tad_tick) begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        sapc_pkg::ST_CONV: begin
          if (abort) begin
            state_q <= sapc_pkg::ST_WAIT;
            cnt_q   <= 5'h00;
          end else if (tad_tick && cnt_q == 5'(`SAPC_CONV_TADS - 1)) begin
            state_q <= sapc_pkg::ST_WAIT;
            cnt_q   <= 5'h00;
            done_q  <= 1'b1;
          end else if (tad_tick) begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        sapc_pkg::ST_WAIT: begin
          // Settling gap before sampling resumes on the channel
          if (start) begin
            state_q <= (acq_tads == 5'h00) ? sapc_pkg::ST_DELAY : sapc_pkg::ST_ACQ;
            cnt_q   <= 5'h00;
          end else if (tad_tick && cnt_q == 5'(`SAPC_WAIT_TADS - 1)) begin
            state_q <= sapc_pkg::ST_SAMPLE;
            cnt_q   <= 5'h00;
          end else if (tad_tick) begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        default: begin
          state_q <= sapc_pkg::ST_SAMPLE;
          cnt_q   <= 5'h00;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  // Go stays high across acquisition and conversion; request wins over clear
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl_main_q <= `SAPC_RST_BYTE;
      ctl_ref_q  <= `SAPC_RST_BYTE;
      ctl_tim_q  <= `SAPC_RST_BYTE;
      dummy_q    <= 1'b0;
    end else begin
      if (wr_main) begin
        ctl_main_q.cal_req <= wdata_i[7];
        ctl_main_q.chan    <= wdata_i[5:2];
        ctl_main_q.on      <= wdata_i[0];
      end
      if (go_req) begin
        ctl_main_q.go <= 1'b1;
      end else if (done_q || abort || (wr_main && !wdata_i[1])) begin
        ctl_main_q.go <= 1'b0;
      end
      // Calibration request turns the next conversion into a dummy one
      if (start) begin
        dummy_q <= ctl_main_q.cal_req;
        if (ctl_main_q.cal_req && !wr_main) begin
          ctl_main_q.cal_req <= 1'b0;
        end
      end
      if (wr_i && hit(addr_i, `SAPC_OFF_CTL_REF)) begin
        ctl_ref_q <= {wdata_i[7], 1'b0, wdata_i[5:0]};
      end
      // Field steers timing; software retunes it for each clock mode
      if (wr_i && hit(addr_i, `SAPC_OFF_CTL_TIM)) begin
        ctl_tim_q <= {wdata_i[7], 1'b0, wdata_i[5:0]};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Result and offset registers
  // ----------------------------------------------------------------------
  // An aborted sample never reaches the result pair
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      res_hi_q <= `SAPC_RST_BYTE;
      res_lo_q <= `SAPC_RST_BYTE;
      offset_q <= 12'h000;
    end else if (done_q && dummy_q) begin
      offset_q <= sample_code_i;
    end else if (done_q) begin
      if (ctl_tim_q.right_just) begin
        res_hi_q <= {4'h0, cal_code[11:8]};
        res_lo_q <= cal_code[7:0];
      end else begin
        res_hi_q <= cal_code[11:4];
        res_lo_q <= {cal_code[3:0], 4'h0};
      end
    end else if (wr_i && hit(addr_i, `SAPC_OFF_RES_HI)) begin
      res_hi_q <= wdata_i;
    end else if (wr_i && hit(addr_i, `SAPC_OFF_RES_LO)) begin
      res_lo_q <= wdata_i;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------------
  // Sticky flag, write one to clear; a new completion beats the clear
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      done_flag_q <= 1'b0;
      int_en_q    <= 1'b0;
      int_prio_q  <= 1'b0;
    end else begin
      if (done_q) begin
        done_flag_q <= 1'b1;
      end else if (wr_i && hit(addr_i, `SAPC_OFF_INT_STAT) && wdata_i[`SAPC_BIT_DONE_FLAG]) begin
        done_flag_q <= 1'b0;
      end
      if (wr_i && hit(addr_i, `SAPC_OFF_INT_CTL)) begin
        int_en_q   <= wdata_i[`SAPC_BIT_INT_EN];
        int_prio_q <= wdata_i[`SAPC_BIT_INT_PRIO];
      end
    end
  end

  // Outputs registered; irq lags the flag by one cycle
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_o      <= 1'b0;
      irq_prio_o <= 1'b0;
      chan_sel_o <= 4'h0;
      vref_sel_o <= 2'h0;
      pin_cfg_o  <= 4'h0;
    end else begin
      irq_o      <= done_flag_q && int_en_q;
      irq_prio_o <= int_prio_q;
      chan_sel_o <= ctl_main_q.chan;
      vref_sel_o <= ctl_ref_q.vref;
      pin_cfg_o  <= ctl_ref_q.pins;
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  // Data valid only in the cycle after the strobe; unused bits read zero
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
    end else if (!rd_i) begin
      rdata_o <= 8'h00;
    end else begin
      unique case (addr_i)
        `SAPC_OFF_RES_HI:   rdata_o <= res_hi_q;
        `SAPC_OFF_RES_LO:   rdata_o <= res_lo_q;
        `SAPC_OFF_CTL_MAIN: rdata_o <= {ctl_main_q.cal_req, 1'b0, ctl_main_q[5:0]};
        `SAPC_OFF_CTL_REF:  rdata_o <= {ctl_ref_q.trig_sel, 1'b0, ctl_ref_q[5:0]};
        `SAPC_OFF_CTL_TIM:  rdata_o <= {ctl_tim_q.right_just, 1'b0, ctl_tim_q[5:0]};
        `SAPC_OFF_INT_STAT: rdata_o <= {7'h00, done_flag_q};
        `SAPC_OFF_INT_CTL:  rdata_o <= {6'h00, int_prio_q, int_en_q};
        default:            rdata_o <= 8'h00;
      endcase
    end
  end

endmodule

`default_nettype wire

// ---- verif/sapc_top_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module sapc_chk (
  input wire logic       mclk_i,     // System clock
  input wire logic       resetn_i,   // Async reset, active low
  input wire logic [2:0] addr_i,     // Register address
  input wire logic [7:0] wdata_i,    // Write data
  input wire logic       wr_i,       // Write strobe
  input wire logic       rd_i,       // Read strobe
  input wire logic [7:0] rdata_o,    // Read data
  input wire logic [3:0] chan_sel_o, // Channel copy
  input wire logic [1:0] vref_sel_o, // Reference copy
  input wire logic [3:0] pin_cfg_o,  // Pin config copy
  input wire logic       irq_o,      // Done interrupt
  input wire logic       irq_prio_o  // Priority copy
);
  // ----------------
  // Bus and copies
  // ----------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  // Write, then two idle cycles so either copy latency has settled
  sequence s_wr_quiet(logic [2:0] a);
    wr_i && addr_i == a ##1 !wr_i [*2];
  endsequence

  rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside read cycle");
  unmapped_rd_a: assert property (rd_i && addr_i == 3'h7 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  rsvd_bit_a: assert property (rd_i && addr_i inside {3'h2, 3'h3, 3'h4} |=> !rdata_o[6])
    else $error("control bit six reads one");
  stat_rsvd_a: assert property (rd_i && addr_i == 3'h5 |=> rdata_o[7:1] == 7'h00)
    else $error("status upper bits not zero");
  irq_mask_a: assert property (wr_i && addr_i == 3'h6 && !wdata_i[0] |-> ##2 !irq_o)
    else $error("interrupt high after mask");
  prio_copy_a: assert property (s_wr_quiet(3'h6) |-> irq_prio_o == $past(wdata_i[1], 2))
    else $error("priority output wrong");
  chan_copy_a: assert property (s_wr_quiet(3'h2) |-> chan_sel_o == $past(wdata_i[5:2], 2))
    else $error("channel output wrong");
  ref_copy_a: assert property (s_wr_quiet(3'h3) |-> {vref_sel_o, pin_cfg_o} == $past(wdata_i[5:0], 2))
    else $error("reference or pin output wrong");
endmodule
`default_nettype wire

// ---- verif/test_sapc_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "sapc_defs.svh"
module test_sapc_top;
  // ----------------
  // Signals
  // ----------------
  logic        mclk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [2:0]  addr_i = 3'h0;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        cpu_run_i = 1'b1;
  logic        sleep_i = 1'b0;
  logic        trig_i = 1'b0;
  logic [11:0] sample_code_i = 12'h000;
  logic [7:0]  rdata_o;
  logic [3:0]  chan_sel_o;
  logic [1:0]  vref_sel_o;
  logic [3:0]  pin_cfg_o;
  logic        irq_o;
  logic        irq_prio_o;
  logic        rd_seen = 1'b0;
  logic [7:0]  exp_q[$];
  logic [7:0]  msk_q[$];
  logic [7:0]  mon_m;
  logic [7:0]  last_hi;
  logic [7:0]  last_lo;
  logic [31:0] r;
  logic [31:0] seed = 32'hC09C62B1;
  logic [11:0] cal_off = 12'h000;
  int          cyc;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          tad[6] = '{2, 4, 8, 16, 32, 64};
  logic [2:0]  sel[6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
  int          acq[8] = '{0, 2, 4, 6, 8, 12, 16, 20};

  sapc_top i_sapc_top (.mclk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .cpu_run_i, .sleep_i,
    .trig_i, .sample_code_i, .chan_sel_o, .vref_sel_o, .pin_cfg_o, .irq_o, .irq_prio_o);

  // 25 MHz clock
  always #20 mclk_i = ~mclk_i;

  // ----------------
  // Helpers
  // ----------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_rng(input string n, input int lo, input int hi, input int g);
    total_checks++;
    if (g < lo || g > hi) begin
      error_cnt++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask

  // One gap cycle after each strobe keeps a driver from assigning twice in a step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  // Read data stands only in the cycle after the strobe; judge it mid-cycle
  always @(posedge mclk_i) rd_seen <= rd_i;
  always @(negedge mclk_i) begin
    if (rd_seen === 1'b1) begin
      mon_m = msk_q.pop_front();
      cmp("rdata", exp_q.pop_front(), rdata_o & mon_m);
    end
  end

  task automatic wait_irq(output int n);
    n = 0;
    while (irq_o !== 1'b1 && n < 3000) begin
      @(negedge mclk_i);
      n++;
    end
    @(posedge mclk_i);
  endtask

  // Mode 0 software start, 1 trigger, 2 Sleep on RC clock, 3 Idle
  task automatic conv(input logic [7:0] tim, input int t, input int a, input int mode);
    logic [3:0] ch;
    int         n;
    int         lo;
    logic [11:0] code;
    r = xs();
    ch = r[15:12];
    sample_code_i <= r[11:0];
    wr(3'h4, tim);
    wr(3'h2, {2'b00, ch, 2'b01});
    if (mode == 1) begin
      trig_i <= 1'b1;
      @(posedge mclk_i);
      trig_i <= 1'b0;
      @(posedge mclk_i);
    end else begin
      wr(3'h2, {2'b00, ch, 2'b11});
    end
    cpu_run_i <= (mode < 2);
    sleep_i <= (mode == 2);
    wait_irq(n);
    lo = (a + 11) * t + ((a == 0) ? 6 : 2);
    chk_rng("conv_cycles", lo, lo + t + 3, n);
    cpu_run_i <= 1'b1;
    sleep_i <= 1'b0;
    // Offset-compensated code, floored at zero once calibration has run
    code = (r[11:0] > cal_off) ? r[11:0] - cal_off : 12'h000;
    last_hi = tim[7] ? {4'h0, code[11:8]} : code[11:4];
    last_lo = tim[7] ? code[7:0] : {code[3:0], 4'h0};
    rd(3'h5, 8'h01, 8'hFF);
    rd(3'h2, {2'b00, ch, 2'b01}, 8'hFF);
    rd(3'h0, last_hi, 8'hFF);
    rd(3'h1, last_lo, 8'hFF);
    wr(3'h5, 8'h01);
    rd(3'h5, 8'h00, 8'hFF);
    // Let the post-conversion wait run out so the next start is not held
    repeat (2 * t + 2) @(posedge mclk_i);
  endtask

  // ----------------
  // Main sequence
  // ----------------
  initial begin
    repeat (6) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(posedge mclk_i);
    for (int i = 0; i < 8; i++) rd(i[2:0], 8'h00, 8'hFF);
    // Random data through the plain registers; main control skipped to keep calibration off
    for (int i = 0; i < 4; i++) begin
      r = xs();
      wr(i[2:0] + i[3:1], r[7:0]);
      rd(i[2:0] + i[3:1], (i >= 2) ? (r[7:0] & 8'hBF) : r[7:0], 8'hFF);
    end
    wr(3'h6, 8'h03);
    repeat (2) @(posedge mclk_i);
    wr(3'h6, 8'h01);
    for (int i = 0; i < 6; i++) conv({i[0], 4'h0, sel[i]}, tad[i], 0, 0);
    for (int i = 1; i < 8; i++) conv({2'b00, i[2:0], 3'h0}, 2, acq[i], 0);
    // Abort mid-conversion: no flag, old result kept
    wr(3'h4, 8'h01);
    wr(3'h2, 8'h03);
    rd(3'h2, 8'h02, 8'h02);
    // Let the start delay pass so the clear lands inside the conversion
    repeat (20) @(posedge mclk_i);
    wr(3'h2, 8'h01);
    repeat (200) @(posedge mclk_i);
    rd(3'h5, 8'h00, 8'hFF);
    rd(3'h0, last_hi, 8'hFF);
    rd(3'h1, last_lo, 8'hFF);
    // Software start refused outside a Run mode
    cpu_run_i <= 1'b0;
    wr(3'h2, 8'h03);
    rd(3'h2, 8'h01, 8'h03);
    cpu_run_i <= 1'b1;
    wr(3'h3, 8'h80);
    repeat (2) @(posedge mclk_i);
    conv(8'h00, 2, 0, 1);
    wr(3'h3, 8'h00);
    conv(8'h05, 16, 0, 3);
    conv(8'h03, `SAPC_RC_TAD_CYC, 0, 2);
    // Calibration: dummy conversion stores the code as offset, result pair untouched
    wr(3'h4, 8'h00);
    sample_code_i <= 12'h0F0;
    wr(3'h2, 8'h81);
    wr(3'h2, 8'h83);
    wait_irq(cyc);
    chk_rng("cal_cycles", 11 * 2 + 6, 11 * 2 + 11, cyc);
    rd(3'h5, 8'h01, 8'hFF);
    rd(3'h2, 8'h01, 8'hFF);
    rd(3'h0, last_hi, 8'hFF);
    rd(3'h1, last_lo, 8'hFF);
    wr(3'h5, 8'h01);
    cal_off = 12'h0F0;
    repeat (6) @(posedge mclk_i);
    conv(8'h80, 2, 0, 0);
    wr(3'h6, 8'h00);
    repeat (4) @(posedge mclk_i);
    final_report();
  end

  // Watchdog well above the sum of all conversion lengths
  initial begin
    repeat (60000) @(posedge mclk_i);
    error_cnt++;
    final_report();
  end
endmodule

bind sapc_top sapc_chk i_sapc_chk (.mclk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .chan_sel_o, .vref_sel_o, .pin_cfg_o, .irq_o, .irq_prio_o);
`default_nettype wire
